/* File: lin_regs_pkg.sv */
// lin_regs_pkg: offsets, field positions, reset values and carrier types for the lin register bank
// assumes: every design file of the bank refers to these by package::name
package lin_regs_pkg;
	localparam logic [7:0] off_data_first = 8'h00;
	localparam logic [7:0] off_data_last = 8'h07;
	localparam logic [7:0] off_frame_control = 8'h08;
	localparam logic [7:0] off_frame_status = 8'h09;
	localparam logic [7:0] off_error_flags = 8'h0a;
	localparam logic [7:0] off_frame_length_checksum = 8'h0b;
	localparam logic [7:0] off_baud_divider_low = 8'h0c;
	localparam logic [7:0] off_baud_multiplier = 8'h0d;
	localparam logic [7:0] off_frame_identifier = 8'h0e;
	// control bit positions
	localparam int bit_stop = 7;
	localparam int bit_sleep = 6;
	localparam int bit_frame_direction = 5;
	localparam int bit_data_request_ack = 4;
	localparam int bit_clear_interrupt_cmd = 3;
	localparam int bit_clear_errors_cmd = 2;
	localparam int bit_wake_request = 1;
	localparam int bit_start_request = 0;
	// status bit positions
	localparam int st_active = 7;
	localparam int st_idle_timeout = 6;
	localparam int st_abort = 5;
	localparam int st_data_request = 4;
	localparam int st_interrupt_pending = 3;
	localparam int st_error = 2;
	localparam int st_wakeup = 1;
	localparam int st_done = 0;
	localparam logic [7:0] reset_byte = 8'h00;
	localparam logic [7:0] error_mask = 8'h1f;
	localparam logic [3:0] length_mask = 4'hf;
	localparam logic [3:0] length_max = 4'h8;
	localparam logic mode_master = 1'b1;
	localparam int fifo_width = 8;
	localparam int fifo_depth = 16;

	// one processor access on the indirect port pair
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} cpu_access_t;

	// events reported by the frame engine
	typedef struct packed {
		logic frame_done;
		logic frame_error;
		logic sync_break;
		logic sleep_frame;
		logic idle_timeout;
		logic wakeup_seen;
		logic data_request;
		logic interrupt;
		logic [4:0] error_bits;
	} engine_event_t;
endpackage

/* File: byte_fifo.sv */
// byte_fifo: synchronous fifo with valid/ready on both sides
// assumes: single clock, asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int width = 8,
	parameter int depth = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [width-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [width-1:0] out_data
);
	localparam int aw = $clog2(depth);
	logic [width-1:0] mem [depth];
	logic [aw-1:0] wptr_reg;
	logic [aw-1:0] rptr_reg;
	logic [aw:0] count_reg;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (count_reg != (aw+1)'(depth));
	assign out_valid = (count_reg != '0);
	assign out_data = mem[rptr_reg];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= rptr_reg + 1'b1;
			end
			count_reg <= count_reg + (aw+1)'(push) - (aw+1)'(pop);
		end
	end

	a_fifo_no_overflow: assert property (@(posedge clk) disable iff (rst)
		count_reg <= (aw+1)'(depth))
		else $error("fifo accepts while full");
endmodule
`default_nettype wire

/* File: lin_ctrl_data_regs.sv */
// lin_ctrl_data_regs: indirect control/data register bank of the lin controller
// assumes: processor accesses arrive on the indirect address/data pair in clk domain;
// the frame engine reports events as one-cycle pulses and takes commands as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - each access to the indirect data port reaches the register chosen by the indirect address.
// - the mode bit selects master when 1 and slave when 0 and resets to master.
// - master-only control bits act only in master mode while bits that are neither master-only nor slave-only work in both modes.
// - slave-only control and status bits act and read only in slave mode.
// - in slave mode writing 1 to bit 7 halts frame processing until the next sync break and it reads 0.
// - in slave mode the sleep bit puts the node asleep on a sleep frame or idle timeout and clearing it wakes on wakeup.
// - control bit 5 picks transmit when 1 and receive when 0 for the current frame.
// - software sets bit 4 to acknowledge a data request and the controller clears it itself.
// - writing 1 to bit 3 clears the pending interrupt flag and the bit reads 0.
// - writing 1 to bit 2 clears all error bits in status and error registers and reads 0.
// - setting bit 1 sends a wakeup on the bus and the controller then clears it.
// - in master mode setting bit 0 starts a frame and it clears on completion or error.
// - the done flag clears when a transmission starts and sets when it finishes; only a start request in master mode clears it, nothing clears it in slave mode.
module lin_ctrl_data_regs (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// indirect processor port
	input wire logic [7:0] indirect_address_port,
	input wire lin_regs_pkg::cpu_access_t cpu,
	output logic [7:0] indirect_data_port,
	// mode select from the control mode register
	input wire logic mode_master_sel,
	// frame engine events
	input wire lin_regs_pkg::engine_event_t evt,
	// frame engine commands
	output logic start_pulse,
	output logic wake_pulse,
	output logic stop_pulse,
	output logic ack_pulse,
	output logic frame_direction,
	output logic sleep_state,
	output logic halted,
	output logic [3:0] data_length,
	output logic enhanced_checksum_sel,
	output logic [7:0] baud_divider_low,
	output logic [7:0] baud_multiplier,
	output logic [7:0] frame_identifier,
	// transmit byte stream, byte 1 first
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data,
	// receive byte stream, byte 1 first
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [7:0] rx_data
);
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic [7:0] data_reg [8];
	logic mode_reg;
	logic sleep_reg, dir_reg, ack_reg, wake_reg, start_reg;
	logic [7:0] status_reg, status_next;
	logic [4:0] error_reg, error_next;
	logic [7:0] size_reg, div_reg, mul_reg, id_reg;
	logic halted_reg, sleep_state_reg;
	logic start_pulse_reg, wake_pulse_reg, stop_pulse_reg, ack_pulse_reg;
	logic [7:0] rdata_reg;
	logic [3:0] load_idx_reg, load_left_reg;
	logic [3:0] fill_idx_reg;
	logic filling_reg;

	wire logic [7:0] wd = cpu.wdata;
	wire logic sel_data = (indirect_address_port <= lin_regs_pkg::off_data_last);
	wire logic [2:0] data_idx = indirect_address_port[2:0];
	wire logic wr_data = cpu.wr && sel_data;
	wire logic wr_ctrl = cpu.wr && (indirect_address_port == lin_regs_pkg::off_frame_control);
	wire logic wr_size = cpu.wr && (indirect_address_port == lin_regs_pkg::off_frame_length_checksum);
	wire logic wr_div = cpu.wr && (indirect_address_port == lin_regs_pkg::off_baud_divider_low);
	wire logic wr_mul = cpu.wr && (indirect_address_port == lin_regs_pkg::off_baud_multiplier);
	wire logic wr_id = cpu.wr && (indirect_address_port == lin_regs_pkg::off_frame_identifier);
	wire logic is_master = mode_reg == lin_regs_pkg::mode_master;
	wire logic is_slave = !is_master;
	// master-only and slave-only command gating
	wire logic cmd_start = wr_ctrl && wd[lin_regs_pkg::bit_start_request] && is_master;
	wire logic cmd_stop = wr_ctrl && wd[lin_regs_pkg::bit_stop] && is_slave;
	wire logic cmd_ack = wr_ctrl && wd[lin_regs_pkg::bit_data_request_ack] && is_slave;
	wire logic cmd_wake = wr_ctrl && wd[lin_regs_pkg::bit_wake_request];
	wire logic cmd_clr_int = wr_ctrl && wd[lin_regs_pkg::bit_clear_interrupt_cmd];
	wire logic cmd_clr_err = wr_ctrl && wd[lin_regs_pkg::bit_clear_errors_cmd];
	wire logic [3:0] len_clip = (size_reg[3:0] > lin_regs_pkg::length_max) ?
		lin_regs_pkg::length_max : (size_reg[3:0] & lin_regs_pkg::length_mask);
	wire logic active_evt = evt.sync_break;

	// control readback: stop and the clear commands read zero, slave bits hidden in master mode
	wire logic [7:0] ctrl_rd = {1'b0, sleep_reg && is_slave, dir_reg, ack_reg && is_slave,
		1'b0, 1'b0, wake_reg, start_reg && is_master};
	wire logic [7:0] slave_st_mask = is_slave ? 8'hff : 8'h8f;
	wire logic [7:0] rd_mux =
		sel_data ? data_reg[data_idx] :
		(indirect_address_port == lin_regs_pkg::off_frame_control) ? ctrl_rd :
		(indirect_address_port == lin_regs_pkg::off_frame_status) ? (status_reg & slave_st_mask) :
		(indirect_address_port == lin_regs_pkg::off_error_flags) ? {3'h0, error_reg} :
		(indirect_address_port == lin_regs_pkg::off_frame_length_checksum) ? size_reg :
		(indirect_address_port == lin_regs_pkg::off_baud_divider_low) ? div_reg :
		(indirect_address_port == lin_regs_pkg::off_baud_multiplier) ? mul_reg :
		(indirect_address_port == lin_regs_pkg::off_frame_identifier) ? id_reg :
		lin_regs_pkg::reset_byte;

	// ----------------------------------------------------------------
	// status and error flags: hardware set beats software clear
	// ----------------------------------------------------------------
	always_comb begin
		status_next = status_reg;
		error_next = error_reg;
		if (cmd_clr_int) begin
			status_next[lin_regs_pkg::st_interrupt_pending] = 1'b0;
		end
		if (cmd_clr_err) begin
			status_next[lin_regs_pkg::st_error] = 1'b0;
			error_next = '0;
		end
		if (cmd_start) begin
			status_next[lin_regs_pkg::st_done] = 1'b0;
		end
		if (cmd_stop) begin
			status_next[lin_regs_pkg::st_abort] = 1'b1;
		end
		if (active_evt) begin
			status_next[lin_regs_pkg::st_active] = 1'b1;
		end
		if (evt.frame_done || evt.frame_error) begin
			status_next[lin_regs_pkg::st_active] = 1'b0;
		end
		if (evt.frame_done) begin
			status_next[lin_regs_pkg::st_done] = 1'b1;
		end
		if (evt.idle_timeout && is_slave) begin
			status_next[lin_regs_pkg::st_idle_timeout] = 1'b1;
		end
		if (cmd_ack) begin
			status_next[lin_regs_pkg::st_data_request] = 1'b0;
		end
		if (evt.data_request && is_slave) begin
			status_next[lin_regs_pkg::st_data_request] = 1'b1;
		end
		if (evt.wakeup_seen || cmd_wake) begin
			status_next[lin_regs_pkg::st_wakeup] = 1'b1;
		end
		if (evt.interrupt) begin
			status_next[lin_regs_pkg::st_interrupt_pending] = 1'b1;
		end
		if (evt.frame_error) begin
			status_next[lin_regs_pkg::st_error] = 1'b1;
			error_next = error_next | (evt.error_bits & lin_regs_pkg::error_mask[4:0]);
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_reg <= lin_regs_pkg::mode_master;
			sleep_reg <= 1'b0;
			dir_reg <= 1'b0;
			size_reg <= lin_regs_pkg::reset_byte;
			div_reg <= lin_regs_pkg::reset_byte;
			mul_reg <= lin_regs_pkg::reset_byte;
			id_reg <= lin_regs_pkg::reset_byte;
			status_reg <= lin_regs_pkg::reset_byte;
			error_reg <= '0;
			rdata_reg <= lin_regs_pkg::reset_byte;
		end else begin
			mode_reg <= mode_master_sel;
			status_reg <= status_next;
			error_reg <= error_next;
			if (cpu.rd || cpu.wr) begin
				rdata_reg <= rd_mux;
			end
			if (wr_ctrl) begin
				dir_reg <= wd[lin_regs_pkg::bit_frame_direction];
				if (is_slave) begin
					sleep_reg <= wd[lin_regs_pkg::bit_sleep];
				end
			end
			if (wr_size) begin
				size_reg <= wd;
			end
			if (wr_div) begin
				div_reg <= wd;
			end
			if (wr_mul) begin
				mul_reg <= wd;
			end
			if (wr_id) begin
				id_reg <= wd;
			end
		end
	end

	// self-clearing command bits and one-cycle command pulses
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			start_reg <= 1'b0;
			wake_reg <= 1'b0;
			ack_reg <= 1'b0;
			start_pulse_reg <= 1'b0;
			wake_pulse_reg <= 1'b0;
			stop_pulse_reg <= 1'b0;
			ack_pulse_reg <= 1'b0;
		end else begin
			start_pulse_reg <= cmd_start;
			wake_pulse_reg <= cmd_wake;
			stop_pulse_reg <= cmd_stop;
			ack_pulse_reg <= cmd_ack;
			if (cmd_start) begin
				start_reg <= 1'b1;
			end else if (evt.frame_done || evt.frame_error) begin
				start_reg <= 1'b0;
			end
			if (cmd_wake) begin
				wake_reg <= 1'b1;
			end else if (wake_pulse_reg) begin
				wake_reg <= 1'b0;
			end
			if (cmd_ack) begin
				ack_reg <= 1'b1;
			end else if (ack_pulse_reg) begin
				ack_reg <= 1'b0;
			end
		end
	end

	// halt and sleep state of the slave
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			halted_reg <= 1'b0;
			sleep_state_reg <= 1'b0;
		end else begin
			if (cmd_stop) begin
				halted_reg <= 1'b1;
			end else if (evt.sync_break) begin
				halted_reg <= 1'b0;
			end
			if (is_slave && sleep_reg && (evt.sleep_frame || evt.idle_timeout)) begin
				sleep_state_reg <= 1'b1;
			end else if ((!sleep_reg && evt.wakeup_seen) || cmd_wake) begin
				sleep_state_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// data byte buffers and streams
	// ----------------------------------------------------------------
	// the fifo decouples byte fetch from the bit engine; bytes load on each transmit start or transmit-direction ack
	logic load_valid;
	logic load_ready;
	assign load_valid = (load_left_reg != 4'h0);

	byte_fifo #(
		.width(lin_regs_pkg::fifo_width),
		.depth(lin_regs_pkg::fifo_depth)
	) tx_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(load_valid),
		.in_ready(load_ready),
		.in_data(data_reg[load_idx_reg[2:0]]),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_data)
	);

	wire logic load_push = load_valid && load_ready;
	wire logic rx_take = rx_valid && filling_reg && (fill_idx_reg < len_clip);
	// a direction written together with the start bit must steer this very frame
	wire logic dir_now = wr_ctrl ? wd[lin_regs_pkg::bit_frame_direction] : dir_reg;
	wire logic tx_frame = cmd_start ? dir_now : 1'b0;
	wire logic fill_start = (cmd_start && !dir_now) || (evt.data_request && is_slave && !dir_now);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			load_idx_reg <= 4'h0;
			load_left_reg <= 4'h0;
			fill_idx_reg <= 4'h0;
			filling_reg <= 1'b0;
		end else begin
			if (tx_frame || (cmd_ack && dir_now)) begin
				load_idx_reg <= 4'h0;
				load_left_reg <= len_clip;
			end else if (load_push) begin
				load_idx_reg <= load_idx_reg + 4'h1;
				load_left_reg <= load_left_reg - 4'h1;
			end
			if (fill_start) begin
				fill_idx_reg <= 4'h0;
				filling_reg <= 1'b1;
			end else if (rx_take) begin
				fill_idx_reg <= fill_idx_reg + 4'h1;
			end else if (evt.frame_done || evt.frame_error) begin
				filling_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < 8; i++) begin
			if (rst) begin
				data_reg[i] <= lin_regs_pkg::reset_byte;
			end else if (rx_take && fill_idx_reg[2:0] == 3'(i)) begin
				data_reg[i] <= rx_data;
			end else if (wr_data && data_idx == 3'(i)) begin
				data_reg[i] <= wd;
			end
		end
	end

	assign rx_ready = filling_reg && (fill_idx_reg < len_clip);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign indirect_data_port = rdata_reg;
	assign start_pulse = start_pulse_reg;
	assign wake_pulse = wake_pulse_reg;
	assign stop_pulse = stop_pulse_reg;
	assign ack_pulse = ack_pulse_reg;
	assign frame_direction = dir_reg;
	assign sleep_state = sleep_state_reg;
	assign halted = halted_reg;
	assign data_length = size_reg[3:0];
	assign enhanced_checksum_sel = size_reg[7];
	assign baud_divider_low = div_reg;
	assign baud_multiplier = mul_reg;
	assign frame_identifier = id_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_start_master_only: assert property (@(posedge clk) disable iff (rst)
		start_pulse_reg |-> $past(mode_reg) == lin_regs_pkg::mode_master)
		else $error("start issued outside master mode");
	a_stop_slave_only: assert property (@(posedge clk) disable iff (rst)
		stop_pulse_reg |-> $past(mode_reg) != lin_regs_pkg::mode_master)
		else $error("stop issued outside slave mode");
	a_stop_halts: assert property (@(posedge clk) disable iff (rst)
		stop_pulse_reg |-> halted_reg)
		else $error("stop did not halt processing");
	a_clear_int: assert property (@(posedge clk) disable iff (rst)
		(cmd_clr_int && !evt.interrupt) |=> !status_reg[lin_regs_pkg::st_interrupt_pending])
		else $error("interrupt flag not cleared");
	a_clear_err: assert property (@(posedge clk) disable iff (rst)
		(cmd_clr_err && !evt.frame_error) |=> (error_reg == '0))
		else $error("error flags not cleared");
	a_wake_selfclear: assert property (@(posedge clk) disable iff (rst)
		(cmd_wake ##1 !cmd_wake) |=> !wake_reg)
		else $error("wake request did not self-clear");
	a_start_clears: assert property (@(posedge clk) disable iff (rst)
		(evt.frame_done && !cmd_start) |=> !start_reg && status_reg[lin_regs_pkg::st_done])
		else $error("start request not cleared on completion");
	a_done_on_start: assert property (@(posedge clk) disable iff (rst)
		(cmd_start && !evt.frame_done) |=> !status_reg[lin_regs_pkg::st_done])
		else $error("done flag not cleared at start");
	a_pulse_one_cycle: assert property (@(posedge clk) disable iff (rst)
		!cmd_start |=> !start_pulse_reg)
		else $error("command pulse longer than one cycle");
endmodule
`default_nettype wire

/* File: lin_engine_model.sv */
// lin_engine_model: behavioural frame engine on the far side of the register bank
// assumes: same clock and reset as the bank; byte streams use valid/ready
`timescale 1ns/1ps
`default_nettype none
module lin_engine_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// transmit stream from the bank
	output logic tx_ready,
	// receive stream into the bank
	input wire logic rx_en,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data
);
	logic [7:0] next_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_ready <= 1'b0;
			rx_valid <= 1'b0;
			rx_data <= 8'hcf;
			next_reg <= 8'h30;
		end else begin
			// stall about one cycle in four so the fifo has to hold bytes back
			tx_ready <= ($urandom_range(3) != 0);
			if (!rx_valid || rx_ready) begin
				if (rx_en && $urandom_range(1)) begin
					rx_valid <= 1'b1;
					rx_data <= next_reg;
					next_reg <= next_reg + 8'h01;
				end else begin
					// a released line shows no stale byte
					rx_valid <= 1'b0;
					rx_data <= ~rx_data;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: testbench.sv */
// testbench: self-checking bench for the lin register bank
// assumes: lin_engine_model stands for the frame engine byte streams
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] adr = 8'h00;
	lin_regs_pkg::cpu_access_t cpu = '0;
	lin_regs_pkg::engine_event_t evt = '0;
	logic msel = 1'b1;
	logic rx_en = 1'b0;
	logic rd_d = 1'b0;
	logic [7:0] rdata, tx_data, rx_data, div, mul, fid, v[3], mem[8];
	logic startp, wakep, stopp, ackp, dir, slp, hlt, ecs, tx_valid, tx_ready, rx_valid, rx_ready;
	logic [3:0] dlen;
	logic [7:0] n_start = 8'h00, n_wake = 8'h00, n_stop = 8'h00, n_ack = 8'h00;
	logic [15:0] note;
	logic [15:0] rd_q[$];
	logic [7:0] tx_q[$];
	int err_count = 0;
	int comparisons = 0;
	int cyc = 0;

	always #2.5 clk = ~clk;

	lin_ctrl_data_regs dut (.clk(clk), .rst(rst), .indirect_address_port(adr), .cpu(cpu),
		.indirect_data_port(rdata), .mode_master_sel(msel), .evt(evt), .start_pulse(startp),
		.wake_pulse(wakep), .stop_pulse(stopp), .ack_pulse(ackp), .frame_direction(dir),
		.sleep_state(slp), .halted(hlt), .data_length(dlen), .enhanced_checksum_sel(ecs),
		.baud_divider_low(div), .baud_multiplier(mul), .frame_identifier(fid),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));

	lin_engine_model far_end (.clk(clk), .rst(rst), .tx_ready(tx_ready), .rx_en(rx_en),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (err_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cyc1();
		@(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cyc1();
		adr = a;
		cpu.wr = 1'b1;
		cpu.wdata = d;
		cyc1();
		cpu.wr = 1'b0;
	endtask

	// the note holds a mask so only defined bits are judged
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		cyc1();
		adr = a;
		cpu.rd = 1'b1;
		rd_q.push_back({m, e & m});
		cyc1();
		cpu.rd = 1'b0;
	endtask

	task automatic ev(input logic [12:0] e);
		cyc1();
		evt = lin_regs_pkg::engine_event_t'(e);
		cyc1();
		evt = '0;
		cyc1();
	endtask

	task automatic tx_frame(input logic [7:0] sz);
		int n;
		n = (sz[3:0] > 4'h8) ? 8 : int'(sz[3:0]);
		wr(8'h0b, sz);
		for (int a = 0; a < n; a++) tx_q.push_back(mem[a]);
		wr(8'h08, 8'h21);
		rd(8'h08, 8'h21);
		rd(8'h09, 8'h00, 8'h01);
		chk8({7'h00, dir}, 8'h01, "direction");
		for (int i = 0; i < 300 && tx_q.size() > 0; i++) cyc1();
		chk8(8'(tx_q.size()), 8'h00, "tx bytes left");
		ev(13'h1000);
		rd(8'h08, 8'h20);
		rd(8'h09, 8'h01, 8'h01);
	endtask

	// ----------------------------------------------------------------
	// watchers
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		rd_d <= cpu.rd;
		cyc <= cyc + 1;
		n_start <= n_start + startp;
		n_wake <= n_wake + wakep;
		n_stop <= n_stop + stopp;
		n_ack <= n_ack + ackp;
		if (tx_valid && tx_ready) begin
			if (tx_q.size() > 0)
				chk8(tx_data, tx_q.pop_front(), "tx byte");
			else
				chk8(tx_data, ~tx_data, "tx extra byte");
		end
		// a hang ends the run as a failure
		if (cyc > 6000) begin
			err_count++;
			tally_and_finish();
		end
	end

	always @(negedge clk) begin
		if (rd_d && rd_q.size() > 0) begin
			note = rd_q.pop_front();
			chk8(rdata & note[15:8], note[7:0], "read data");
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h0249119d));
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int a = 0; a < 16; a++) rd(8'(a), 8'h00);
		for (int a = 0; a < 8; a++) begin
			mem[a] = 8'($urandom);
			wr(8'(a), mem[a]);
		end
		v[0] = 8'($urandom);
		v[1] = 8'($urandom);
		v[2] = 8'($urandom) & 8'h3f;
		for (int a = 0; a < 3; a++) wr(8'(8'h0c + a), v[a]);
		wr(8'h09, 8'hff);
		wr(8'h0a, 8'hff);
		for (int a = 0; a < 8; a++) rd(8'(a), mem[a]);
		for (int a = 0; a < 3; a++) rd(8'(8'h0c + a), v[a]);
		rd(8'h09, 8'h00);
		rd(8'h0a, 8'h00);
		chk8(div, v[0], "divider");
		chk8(mul, v[1], "multiplier");
		chk8(fid, v[2], "identifier");
		tx_frame(8'h83);
		chk8({ecs, 3'b000, dlen}, 8'h83, "size fields");
		tx_frame(8'h0c);
		chk8(n_start, 8'h02, "start pulses");
		// master: start a frame, then error and interrupt events
		wr(8'h0b, 8'h00);
		wr(8'h08, 8'h01);
		chk8({7'h00, dir}, 8'h00, "receive direction");
		ev(13'h0020);
		ev(13'h0807);
		rd(8'h08, 8'h00, 8'h01);
		rd(8'h09, 8'h0c, 8'h0c);
		rd(8'h0a, 8'h07, 8'h07);
		wr(8'h08, 8'h08);
		rd(8'h09, 8'h04, 8'h0c);
		rd(8'h08, 8'h00, 8'h08);
		wr(8'h08, 8'h04);
		rd(8'h09, 8'h00, 8'h0c);
		rd(8'h0a, 8'h00, 8'h07);
		wr(8'h08, 8'h02);
		cyc1();
		rd(8'h08, 8'h00, 8'h02);
		chk8(n_wake, 8'h01, "wake pulses");
		wr(8'h08, 8'h90);
		ev(13'h0200);
		chk8(n_stop | n_ack, 8'h00, "stop or ack in master");
		chk8({7'h00, slp}, 8'h00, "sleep in master");
		// slave mode
		msel = 1'b0;
		repeat (2) cyc1();
		wr(8'h08, 8'h01);
		rd(8'h08, 8'h00, 8'h01);
		chk8(n_start, 8'h03, "start in slave");
		wr(8'h08, 8'h80);
		rd(8'h08, 8'h00, 8'h80);
		chk8({n_stop[6:0], hlt}, 8'h03, "stop halts");
		ev(13'h0400);
		chk8({7'h00, hlt}, 8'h00, "sync break resumes");
		wr(8'h08, 8'h40);
		ev(13'h0200);
		chk8({7'h00, slp}, 8'h01, "sleep frame");
		wr(8'h08, 8'h00);
		ev(13'h0080);
		chk8({7'h00, slp}, 8'h00, "wakeup");
		wr(8'h08, 8'h40);
		ev(13'h0100);
		chk8({7'h00, slp}, 8'h01, "idle timeout");
		rd(8'h09, 8'h40, 8'h40);
		wr(8'h08, 8'h00);
		ev(13'h0080);
		// slave receive of four bytes from the far end
		wr(8'h0b, 8'h04);
		rx_en = 1'b1;
		ev(13'h0040);
		for (int i = 0; i < 300 && rx_ready !== 1'b0; i++) cyc1();
		rx_en = 1'b0;
		rd(8'h09, 8'h10, 8'h10);
		for (int a = 0; a < 4; a++) rd(8'(a), 8'(8'h30 + a));
		rd(8'h04, mem[4]);
		wr(8'h08, 8'h10);
		cyc1();
		rd(8'h08, 8'h00, 8'h10);
		chk8(n_ack, 8'h01, "ack pulses");
		msel = 1'b1;
		repeat (2) cyc1();
		rd(8'h09, 8'h00, 8'h70);
		repeat (4) cyc1();
		tally_and_finish();
	end
endmodule
`default_nettype wire
